/* src/xct_pkg.sv */
// package: constants and carriers for the board test parity chain
// Contract
// - low frame start and bit zero at reset release enter test mode.
// - either frame start or bit zero high at reset release leaves test mode.
// - power-on reset forces test mode off whatever the select pins show.
// - in test mode normal functions cut off; pins inputs, chain output driven.
// - in test mode any single chain input change toggles the chain output.
// - host reset, supplies, grounds and chain output pin are not chain inputs.
// - after entry frame start and bit zero act as ordinary chain inputs.
// - all chain inputs low in test mode gives a low chain output.
// - after exit, toggling inputs no longer changes the chain output.
package xct_pkg;

  // number of chain inputs besides the two mode-select pins
  localparam int unsigned CHAIN_OTHER_W = 88;
  localparam logic        MODE_OFF      = 1'h0;
  localparam logic        SYNC_IDLE     = 1'h1;
  localparam logic        PAR_ZERO      = 1'h0;
  localparam logic        CHAIN_IDLE    = 1'h0;
  localparam logic        DRIVE_ON      = 1'h1;
  localparam logic        DRIVE_OFF     = 1'h0;
  // select pins that join the chain once the mode is entered
  localparam int unsigned CHAIN_SEL_W   = 2;

  typedef struct packed {
    logic host_bus_reset_n;
    logic frame_start_n;
    logic addr_data_bit_zero;
  } xct_sel_type;

endpackage

/* src/xct_board_test.sv */
// module: board test mode latch and parity chain onto the observation pin
`timescale 1ns/1ps

module xct_board_test #(
  parameter int unsigned OTHER_W = xct_pkg::CHAIN_OTHER_W
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 por_i,
  input  wire xct_pkg::xct_sel_type sel_i,
  input  wire logic [OTHER_W-1:0]   chain_in_i,
  input  wire logic                 func_out_i,
  input  wire logic                 func_oe_i,
  output logic                      test_mode_o,
  output logic                      chain_output_pin_o,
  output logic                      chain_output_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // widths and idle levels

  localparam int unsigned SEL_W  = $bits(xct_pkg::xct_sel_type);
  localparam int unsigned MEMB_W = OTHER_W + xct_pkg::CHAIN_SEL_W;

  // selects idle high so block reset never looks like a host release
  localparam logic SYNC_IDLE_V  = xct_pkg::SYNC_IDLE;
  localparam logic CHAIN_IDLE_V = xct_pkg::CHAIN_IDLE;

  // the chain needs at least one ordinary pin beside the two selects
  if (OTHER_W < 1) begin : g_chk
    $error("xct_board_test: OTHER_W must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the select pins

  logic [SEL_W-1:0] sel_raw_w;
  logic [SEL_W-1:0] sel_meta_q;
  logic [SEL_W-1:0] sel_sync_q;

  assign sel_raw_w = sel_i;

  for (genvar b = 0; b < SEL_W; b++) begin : g_sel_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sel_meta_q[b] <= SYNC_IDLE_V;
      end else begin
        sel_meta_q[b] <= sel_raw_w[b];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sel_sync_q[b] <= SYNC_IDLE_V;
      end else begin
        sel_sync_q[b] <= sel_meta_q[b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the ordinary chain pins

  logic [OTHER_W-1:0] chain_meta_q;
  logic [OTHER_W-1:0] chain_sync_q;

  for (genvar c = 0; c < OTHER_W; c++) begin : g_chain_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        chain_meta_q[c] <= CHAIN_IDLE_V;
      end else begin
        chain_meta_q[c] <= chain_in_i[c];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        chain_sync_q[c] <= CHAIN_IDLE_V;
      end else begin
        chain_sync_q[c] <= chain_meta_q[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronised view of the selects

  xct_pkg::xct_sel_type sel_sync_w;

  assign sel_sync_w = sel_sync_q;

  ////////////////////////////////////////////////////////////////////////
  // host reset release detector

  logic host_rst_prev_q;
  logic release_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_rst_prev_q <= SYNC_IDLE_V;
    end else begin
      host_rst_prev_q <= sel_sync_w.host_bus_reset_n;
    end
  end

  // low-to-high of the synchronised host reset, one cycle wide
  assign release_w = sel_sync_w.host_bus_reset_n & ~host_rst_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // select decode, acted on only at a release

  logic enter_req_w;

  // both low asks for the chain, either high asks for normal function
  assign enter_req_w = ~sel_sync_w.frame_start_n
                     & ~sel_sync_w.addr_data_bit_zero;

  ////////////////////////////////////////////////////////////////////////
  // mode state machine

  typedef enum logic [1:0] {
    ST_NORMAL = 2'h1,
    ST_CHAIN  = 2'h2
  } xct_mode_type;

  xct_mode_type state_q;
  xct_mode_type state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (release_w && enter_req_w) begin
          state_d = ST_CHAIN;
        end
      end
      ST_CHAIN: begin
        if (release_w && !enter_req_w) begin
          state_d = ST_NORMAL;
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
  end

  // power-on reset wins over a release in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      state_q <= ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  logic mode_w;

  assign mode_w = (state_q == ST_CHAIN);

  ////////////////////////////////////////////////////////////////////////
  // parity chain; host reset never joins, selects join once in mode

  logic [MEMB_W-1:0] member_w;
  logic [MEMB_W:0]   chain_acc_w;

  assign member_w = {chain_sync_q,
                     sel_sync_w.frame_start_n,
                     sel_sync_w.addr_data_bit_zero};

  // zero seed so an all-low pin set reads low
  assign chain_acc_w[0] = xct_pkg::PAR_ZERO;

  // linear ripple: long path, but board-test pins move slowly
  for (genvar m = 0; m < MEMB_W; m++) begin : g_chain
    assign chain_acc_w[m+1] = chain_acc_w[m] ^ member_w[m];
  end

  ////////////////////////////////////////////////////////////////////////
  // output next values

  logic test_mode_d;
  logic pin_level_d;
  logic pin_oe_d;

  always_comb begin
    test_mode_d = mode_w;
  end

  always_comb begin
    pin_level_d = func_out_i;
    if (mode_w) begin
      pin_level_d = chain_acc_w[MEMB_W];
    end
  end

  always_comb begin
    pin_oe_d = func_oe_i;
    if (mode_w) begin
      pin_oe_d = xct_pkg::DRIVE_ON;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs, one process per concern

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_mode_o <= xct_pkg::MODE_OFF;
    end else begin
      test_mode_o <= test_mode_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_output_pin_o <= xct_pkg::PAR_ZERO;
    end else begin
      chain_output_pin_o <= pin_level_d;
    end
  end

  // pin released in block reset; functional drive returns after exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_output_pin_oe_o <= xct_pkg::DRIVE_OFF;
    end else begin
      chain_output_pin_oe_o <= pin_oe_d;
    end
  end

endmodule

/* tb/xct_checker.sv */
// checker: board test mode port relations
`timescale 1ns/1ps

module xct_checker #(
  parameter int unsigned OTHER_W = xct_pkg::CHAIN_OTHER_W
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 por_i,
  input  wire xct_pkg::xct_sel_type sel_i,
  input  wire logic [OTHER_W-1:0]   chain_in_i,
  input  wire logic                 func_out_i,
  input  wire logic                 func_oe_i,
  input  wire logic                 test_mode_o,
  input  wire logic                 chain_output_pin_o,
  input  wire logic                 chain_output_pin_oe_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a pin reaches the output three edges after it is sampled
  property p_par;
    test_mode_o |-> chain_output_pin_o ==
      ^{$past(chain_in_i, 3), $past(sel_i.frame_start_n, 3),
        $past(sel_i.addr_data_bit_zero, 3)};
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");

  property p_oe;
    test_mode_o |-> chain_output_pin_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not driven");

  property p_por;
    por_i |-> ##2 !test_mode_o;
  endproperty
  a_por: assert property (p_por) else $error("mode kept");

  property p_off;
    !test_mode_o && !$past(rst_i) |->
      chain_output_pin_o == $past(func_out_i) &&
      chain_output_pin_oe_o == $past(func_oe_i);
  endproperty
  a_off: assert property (p_off) else $error("pin not normal");

  property p_entry;
    ($rose(sel_i.host_bus_reset_n) && !sel_i.frame_start_n &&
      !sel_i.addr_data_bit_zero) ##1 (!por_i)[*2] |-> ##2 test_mode_o;
  endproperty
  a_entry: assert property (p_entry) else $error("no entry");

  property p_exit;
    $rose(sel_i.host_bus_reset_n) &&
      (sel_i.frame_start_n || sel_i.addr_data_bit_zero) |->
      ##4 !test_mode_o;
  endproperty
  a_exit: assert property (p_exit) else $error("no exit");

  c_in: cover property ($rose(test_mode_o));
  c_out: cover property ($fell(test_mode_o));
  c_tog: cover property (test_mode_o && $changed(chain_output_pin_o));

endmodule

bind xct_board_test xct_checker #(
  .OTHER_W(OTHER_W)
) u_chk (
  .clk_i                 (clk_i),
  .rst_i                 (rst_i),
  .por_i                 (por_i),
  .sel_i                 (sel_i),
  .chain_in_i            (chain_in_i),
  .func_out_i            (func_out_i),
  .func_oe_i             (func_oe_i),
  .test_mode_o           (test_mode_o),
  .chain_output_pin_o    (chain_output_pin_o),
  .chain_output_pin_oe_o (chain_output_pin_oe_o)
);

/* tb/xct_tester.sv */
// partner: board tester driving chain pins and host bus reset
`timescale 1ns/1ps
module xct_tester (
  input  wire logic       clk_i,
  output logic [5:0]      pins_o,
  output logic            rst_n_o
);

  initial begin
    pins_o = 6'h00;
    rst_n_o = 1'h0;
  end

  // selects held well past release so the decision sees them
  task automatic release_reset(input logic [1:0] s);
    pins_o[1:0] = s;
    rst_n_o = 1'h0;
    repeat (4) @(posedge clk_i);
    #1 rst_n_o = 1'h1;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic set_pin(input int i, input logic v);
    pins_o[i] = v;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

endmodule

/* tb/tb_top.sv */
// testbench: mode entry and exit, parity walk, power-on reset
`timescale 1ns/1ps
module tb_top;

  logic                 clk_i;
  logic                 rst_i;
  logic                 por_i;
  logic                 fo;
  logic                 tm;
  logic                 po;
  logic                 oe;
  logic                 nr;
  logic [5:0]           p;
  xct_pkg::xct_sel_type sel_w;
  int                   mismatches = 0;
  int                   check_count = 0;

  assign sel_w = {nr, p[1:0]};

  xct_tester tst (
    .clk_i   (clk_i),
    .pins_o  (p),
    .rst_n_o (nr)
  );

  xct_board_test #(
    .OTHER_W(4)
  ) uut (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .por_i                 (por_i),
    .sel_i                 (sel_w),
    .chain_in_i            (p[5:2]),
    .func_out_i            (fo),
    .func_oe_i             (fo),
    .test_mode_o           (tm),
    .chain_output_pin_o    (po),
    .chain_output_pin_oe_o (oe)
  );

  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic cmp(input logic a, input logic e);
    check_count++;
    if (a !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t %h %h", $time, a, e);
    end
  endtask

  task automatic summarize;
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // tester order: raise from the top, lower from the bottom
  task automatic t_walk;
    tst.release_reset(2'h0);
    cmp(tm, 1'h1);
    cmp(oe, 1'h1);
    cmp(po, 1'h0);
    for (int i = 5; i >= 0; i--) begin
      tst.set_pin(i, 1'h1);
      cmp(po, i[0]);
    end
    for (int i = 0; i < 6; i++) begin
      tst.set_pin(i, 1'h0);
      cmp(po, ~i[0]);
    end
    tst.release_reset(2'h0);
    cmp(tm, 1'h1);
    cmp(po, 1'h0);
  endtask

  // two toggles after exit: each of them would flip a live parity
  task automatic t_exit;
    for (int s = 1; s < 4; s++) begin
      tst.release_reset(2'h0);
      cmp(tm, 1'h1);
      tst.release_reset(s[1:0]);
      cmp(tm, 1'h0);
      cmp(oe, fo);
      tst.set_pin(5, ~p[5]);
      cmp(po, fo);
      tst.set_pin(4, ~p[4]);
      cmp(po, fo);
    end
  endtask

  task automatic t_por;
    tst.release_reset(2'h0);
    cmp(tm, 1'h1);
    fo = 1'h1;
    @(posedge clk_i);
    #1 por_i = 1'h1;
    @(posedge clk_i);
    #1 por_i = 1'h0;
    repeat (3) @(posedge clk_i);
    #1 cmp(tm, 1'h0);
    cmp(po, 1'h1);
    cmp(oe, 1'h1);
  endtask

  initial begin
    rst_i = 1'h1;
    por_i = 1'h0;
    fo = 1'h0;
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'h0;
    t_walk;
    t_exit;
    t_por;
    summarize;
  end

  // tests need well under a thousand cycles; this allows ample margin
  initial begin
    #40000;
    mismatches++;
    summarize;
  end

endmodule
